// file: shared/psm_defs.vh
`ifndef PSM_DEFS_VH
`define PSM_DEFS_VH

// Timing: system clock period and the monitor and settle times in ns.
`define PSM_CLK_NS       40
`define PSM_WIN_NS       40000
`define PSM_WIN_CYC      (`PSM_WIN_NS / `PSM_CLK_NS)
`define PSM_GAP_NS       2000
`define PSM_GAP_CYC      (`PSM_GAP_NS / `PSM_CLK_NS)
`define PSM_SETTLE_NS    4000
`define PSM_SETTLE_CYC   (`PSM_SETTLE_NS / `PSM_CLK_NS)

// Register indices on the address port.
`define PSM_REG_CTRL_A   4'h0
`define PSM_REG_CTRL_C   4'h1
`define PSM_REG_CTRL_D   4'h2
`define PSM_REG_PRIO_A   4'h3
`define PSM_REG_PRIO_C   4'h4
`define PSM_REG_PRIO_D   4'h5
`define PSM_REG_RAMP     4'h6
`define PSM_REG_TOL      4'h7
`define PSM_REG_EXP0     4'h8
`define PSM_REG_EXP3     4'hB
`define PSM_REG_STATUS   4'hC
`define PSM_REG_SELECT   4'hD

// Loop control field positions.
`define PSM_CTRL_SEL_LO  0
`define PSM_CTRL_SEL_HI  2
`define PSM_CTRL_AUTO    3
`define PSM_CTRL_REV     4
`define PSM_CTRL_HITLESS 5
`define PSM_CTRL_RSWITCH 6
`define PSM_CTRL_REXIT   7
`define PSM_CTRL_FAST    8

// Reset values.
`define PSM_CTRL_RST     9'h000
`define PSM_PRIO_RST     18'h00000
`define PSM_RAMP_RST     6'h00
`define PSM_TOL_RST      16'h0010
`define PSM_EXP_RST      16'h03E8

// Ramp rate code range, slowest to fastest.
`define PSM_RAMP_MAX     6'h29

// Candidate masks: loops A and C see only the shared inputs and the reference.
`define PSM_ALLOW_AC     6'h0F
`define PSM_ALLOW_D      6'h3F

`endif

// file: verilog/psm_mon.v
`include "psm_defs.vh"

module psm_mon #(
	parameter HAS_FREQ = 1,
	parameter WIN_CYC  = `PSM_WIN_CYC,
	parameter GAP_CYC  = `PSM_GAP_CYC
) (
	input  wire        clock_i,
	input  wire        rst_i,
	input  wire        clk_in_i,
	input  wire [15:0] exp_cnt_i,
	input  wire [15:0] tol_i,
	output reg         loss_o,
	output reg         fault_o
);

	reg        prev_reg;
	reg [15:0] gap_reg;
	reg [15:0] win_reg;
	reg [15:0] cnt_reg;
	wire       edge_seen = clk_in_i & ~prev_reg;
	wire [16:0] lo_sum = {1'b0, cnt_reg} + {1'b0, tol_i};
	wire [16:0] hi_sum = {1'b0, exp_cnt_i} + {1'b0, tol_i};

	// The gap limit spans several input periods, so a gapped clock missing two of eight cycles never trips it.
	always @(posedge clock_i)
	begin
		if (rst_i)
		begin
			prev_reg <= 1'b0;
			gap_reg  <= 16'h0000;
			win_reg  <= 16'h0000;
			cnt_reg  <= 16'h0000;
			loss_o   <= 1'b1;
			fault_o  <= 1'b0;
		end
		else
		begin
			prev_reg <= clk_in_i;
			if (edge_seen)
				gap_reg <= 16'h0000;
			else if (gap_reg < GAP_CYC)
				gap_reg <= gap_reg + 16'h0001;
			loss_o <= ~edge_seen & (gap_reg >= GAP_CYC - 1);
			if (win_reg >= WIN_CYC - 1)
			begin
				win_reg <= 16'h0000;
				cnt_reg <= {15'h0000, edge_seen};
				// The count over a full window is the average rate, so gaps only lower it evenly.
				fault_o <= (HAS_FREQ != 0) && ((lo_sum < {1'b0, exp_cnt_i}) || ({1'b0, cnt_reg} > hi_sum));
			end
			else
			begin
				win_reg <= win_reg + 16'h0001;
				if (edge_seen && cnt_reg != 16'hFFFF)
					cnt_reg <= cnt_reg + 16'h0001;
			end
		end
	end

endmodule // psm_mon

// file: verilog/psm_top.v
`include "psm_defs.vh"

// Notes on behaviour
// - Loops A and C have four candidates, loop D six.
// - Shared inputs and reference may feed any loop.
// - The two extra inputs reach only loop D.
// - Selection is manual or automatic; automatic needs fewer than five enabled inputs.
// - Manual select picks from the loop's permitted set by register write.
// - Manual choice without a clock sends the loop into holdover by itself.
// - Automatic mode picks the valid input of highest priority.
// - Priority is per loop; revertive or non-revertive per loop.
// - Hitless switch between locked inputs absorbs the phase difference.
// - Without hitless the phase step passes at loop bandwidth rate.
// - Hitless has a per-loop enable and works down to 8 kHz.
// - One ramp rate serves both ramped switching and ramped holdover exit.
// - Switch inputs up to 500 ppm apart, pull in with normal or fast bandwidth.
// - Lock loss shows during pull-in; switching is glitchless on every input.
// - Gapped inputs of at least 10 MHz are averaged into a periodic clock.
// - Valid gapped inputs trip no loss, frequency or lock monitor.
// - Shared inputs and reference have signal-loss and frequency monitors.
// - The crystal reference has a signal-loss monitor.
// - Each loop has a lock-loss indicator set on lost synchronization.
// - The extra inputs have signal-loss monitoring only.
// - Holdover when no valid input remains; leave it when one returns.
// - Ramp rate codes span 0.2 ppm/s to 40000 ppm/s.
module psm_top #(
	parameter WIN_CYC    = `PSM_WIN_CYC,
	parameter GAP_CYC    = `PSM_GAP_CYC,
	parameter SETTLE_CYC = `PSM_SETTLE_CYC
) (
	input  wire        clock_i,
	input  wire        rst_i,
	input  wire [5:0]  in_clk_i,
	input  wire        crystal_reference_pins_i,
	input  wire [2:0]  loop_freq_err_i,
	input  wire [3:0]  addr_i,
	input  wire [31:0] wdata_i,
	input  wire        wr_i,
	input  wire        rd_i,
	output reg  [31:0] rdata_o,
	output wire [8:0]  sel_o,
	output wire [2:0]  holdover_o,
	output wire [2:0]  lock_loss_flag_o,
	output wire [2:0]  phase_absorb_o,
	output wire [2:0]  ramp_active_o,
	output wire [2:0]  fast_bw_o,
	output reg  [5:0]  ramp_rate_o,
	output wire [5:0]  signal_loss_flag_o,
	output wire [3:0]  frequency_fault_flag_o,
	output wire        crystal_loss_o
);

	localparam ST_FREE   = 4'h1;
	localparam ST_PULLIN = 4'h2;
	localparam ST_LOCKED = 4'h4;
	localparam ST_HOLD   = 4'h8;

	reg  [8:0]  ctrl_reg [0:2];
	reg  [17:0] prio_reg [0:2];
	reg  [15:0] tol_reg;
	reg  [15:0] exp_reg [0:3];
	wire [5:0]  signal_loss_flag;
	wire [5:0]  frequency_fault_flag;
	wire [5:0]  valid;
	integer     k;

	// Index of the best candidate among v with the highest nonzero priority; ties go to the lower index.
	function [3:0] pick_best;
		input [5:0]  v;
		input [17:0] p;
		integer      i;
		reg   [2:0]  bp;
		begin
			bp = 3'h0;
			pick_best = 4'h0;
			for (i = 0; i < 6; i = i + 1)
				if (v[i] && p[i*3 +: 3] > bp)
				begin
					bp = p[i*3 +: 3];
					pick_best = {1'b1, i[2:0]};
				end
		end
	endfunction

	function [2:0] count6;
		input [5:0] v;
		integer     i;
		begin
			count6 = 3'h0;
			for (i = 0; i < 6; i = i + 1)
				count6 = count6 + {2'h0, v[i]};
		end
	endfunction

	function bit6;
		input [5:0] v;
		input [2:0] idx;
		begin
			bit6 = (idx < 3'h6) ? v[idx] : 1'b0;
		end
	endfunction

	function [5:0] prio_mask;
		input [17:0] p;
		input [5:0]  allow;
		integer      i;
		begin
			prio_mask = 6'h00;
			for (i = 0; i < 6; i = i + 1)
				prio_mask[i] = (|p[i*3 +: 3]) & allow[i];
		end
	endfunction

	genvar m;
	generate
		for (m = 0; m < 6; m = m + 1)
		begin : g_mon
			// Shared inputs and reference get both monitors; the extra inputs loss only.
			psm_mon #(
				.HAS_FREQ (m < 4 ? 1 : 0),
				.WIN_CYC  (WIN_CYC),
				.GAP_CYC  (GAP_CYC)
			) u_mon (
				.clock_i   (clock_i),
				.rst_i     (rst_i),
				.clk_in_i  (in_clk_i[m]),
				.exp_cnt_i (exp_reg[m < 4 ? m : 0]),
				.tol_i     (tol_reg),
				.loss_o    (signal_loss_flag[m]),
				.fault_o   (frequency_fault_flag[m])
			);
			assign valid[m] = ~signal_loss_flag[m] & ~frequency_fault_flag[m];
		end
	endgenerate

	// The crystal clock is watched for loss only.
	psm_mon #(
		.HAS_FREQ (0),
		.WIN_CYC  (WIN_CYC),
		.GAP_CYC  (GAP_CYC)
	) u_mon_xtal (
		.clock_i   (clock_i),
		.rst_i     (rst_i),
		.clk_in_i  (crystal_reference_pins_i),
		.exp_cnt_i (`PSM_EXP_RST),
		.tol_i     (tol_reg),
		.loss_o    (crystal_loss_o),
		.fault_o   ()
	);

	assign signal_loss_flag_o     = signal_loss_flag;
	assign frequency_fault_flag_o = frequency_fault_flag[3:0];

	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1)
		begin : g_loop
			wire [8:0]  ctrl  = ctrl_reg[g];
			wire [17:0] prio  = prio_reg[g];
			wire [5:0]  allow = (g == 2) ? `PSM_ALLOW_D : `PSM_ALLOW_AC;
			wire [5:0]  enab  = prio_mask(prio, allow);
			wire        auto_eff = ctrl[`PSM_CTRL_AUTO] & (count6(enab) < 3'h5);
			wire [3:0]  best  = pick_best(valid & enab, prio);
			wire [2:0]  msel  = ctrl[`PSM_CTRL_SEL_HI:`PSM_CTRL_SEL_LO];
			reg  [3:0]  st_reg;
			reg  [2:0]  sel_reg;
			reg  [7:0]  settle_reg;
			reg         lol_reg;
			reg         hold_reg;
			reg         absorb_reg;
			reg         ramp_reg;
			reg         fast_reg;
			reg         want_found;
			reg  [2:0]  want_idx;

			always @*
			begin
				want_found = 1'b0;
				want_idx   = sel_reg;
				if (auto_eff)
				begin
					// Non-revertive keeps a still-valid current input even if a better one returns.
					if (!ctrl[`PSM_CTRL_REV] && (st_reg == ST_PULLIN || st_reg == ST_LOCKED)
						&& bit6(valid & enab, sel_reg))
						want_found = 1'b1;
					else
					begin
						want_found = best[3];
						want_idx   = best[2:0];
					end
				end
				else
				begin
					// A manual choice with no clock or outside the permitted set leads to holdover.
					want_found = bit6(allow, msel) & ~bit6(signal_loss_flag, msel);
					want_idx   = msel;
				end
			end

			always @(posedge clock_i)
			begin
				if (rst_i)
				begin
					st_reg     <= ST_FREE;
					sel_reg    <= 3'h0;
					settle_reg <= 8'h00;
					lol_reg    <= 1'b1;
					hold_reg   <= 1'b0;
					absorb_reg <= 1'b0;
					ramp_reg   <= 1'b0;
					fast_reg   <= 1'b0;
				end
				else
				begin
					absorb_reg <= 1'b0;
					case (st_reg)
						ST_FREE:
						begin
							if (want_found)
							begin
								sel_reg    <= want_idx;
								st_reg     <= ST_PULLIN;
								settle_reg <= 8'h00;
								fast_reg   <= ctrl[`PSM_CTRL_FAST];
							end
						end
						ST_PULLIN, ST_LOCKED:
						begin
							if (!want_found)
							begin
								st_reg   <= ST_HOLD;
								hold_reg <= 1'b1;
								lol_reg  <= 1'b1;
								ramp_reg <= 1'b0;
								fast_reg <= 1'b0;
							end
							else if (want_idx != sel_reg)
							begin
								// The selection moves and lock loss is raised; the loop pulls in again, so no runt pulse reaches the output.
								sel_reg    <= want_idx;
								st_reg     <= ST_PULLIN;
								settle_reg <= 8'h00;
								lol_reg    <= 1'b1;
								absorb_reg <= ctrl[`PSM_CTRL_HITLESS];
								ramp_reg   <= ctrl[`PSM_CTRL_RSWITCH];
								fast_reg   <= ctrl[`PSM_CTRL_FAST];
							end
							else if (st_reg == ST_PULLIN)
							begin
								if (loop_freq_err_i[g])
									settle_reg <= 8'h00;
								else if (settle_reg >= SETTLE_CYC - 1)
								begin
									st_reg   <= ST_LOCKED;
									lol_reg  <= 1'b0;
									ramp_reg <= 1'b0;
									fast_reg <= 1'b0;
								end
								else
									settle_reg <= settle_reg + 8'h01;
							end
							else if (loop_freq_err_i[g])
							begin
								st_reg     <= ST_PULLIN;
								settle_reg <= 8'h00;
								lol_reg    <= 1'b1;
							end
						end
						ST_HOLD:
						begin
							if (want_found)
							begin
								sel_reg    <= want_idx;
								st_reg     <= ST_PULLIN;
								settle_reg <= 8'h00;
								hold_reg   <= 1'b0;
								ramp_reg   <= ctrl[`PSM_CTRL_REXIT];
								fast_reg   <= ctrl[`PSM_CTRL_FAST];
							end
						end
						default:
						begin
							st_reg  <= ST_FREE;
							lol_reg <= 1'b1;
						end
					endcase
				end
			end

			assign sel_o[g*3 +: 3]     = sel_reg;
			assign holdover_o[g]       = hold_reg;
			assign lock_loss_flag_o[g] = lol_reg;
			assign phase_absorb_o[g]   = absorb_reg;
			assign ramp_active_o[g]    = ramp_reg;
			assign fast_bw_o[g]        = fast_reg;
		end
	endgenerate

	// Register writes. The ramp and switching choices are left to software.
	always @(posedge clock_i)
	begin
		if (rst_i)
		begin
			for (k = 0; k < 3; k = k + 1)
			begin
				ctrl_reg[k] <= `PSM_CTRL_RST;
				prio_reg[k] <= `PSM_PRIO_RST;
			end
			for (k = 0; k < 4; k = k + 1)
				exp_reg[k] <= `PSM_EXP_RST;
			tol_reg     <= `PSM_TOL_RST;
			ramp_rate_o <= `PSM_RAMP_RST;
		end
		else if (wr_i)
		begin
			case (addr_i)
				`PSM_REG_CTRL_A, `PSM_REG_CTRL_C, `PSM_REG_CTRL_D:
					ctrl_reg[addr_i[1:0]] <= wdata_i[8:0];
				`PSM_REG_PRIO_A:
					prio_reg[0] <= wdata_i[17:0];
				`PSM_REG_PRIO_C:
					prio_reg[1] <= wdata_i[17:0];
				`PSM_REG_PRIO_D:
					prio_reg[2] <= wdata_i[17:0];
				`PSM_REG_RAMP:
					// Codes above the fastest rate clamp to it.
					ramp_rate_o <= (wdata_i[5:0] > `PSM_RAMP_MAX) ? `PSM_RAMP_MAX : wdata_i[5:0];
				`PSM_REG_TOL:
					tol_reg <= wdata_i[15:0];
				default:
				begin
					if (addr_i >= `PSM_REG_EXP0 && addr_i <= `PSM_REG_EXP3)
						exp_reg[addr_i[1:0]] <= wdata_i[15:0];
				end
			endcase
		end
	end

	// Read data stand for one cycle after the strobe and are zero otherwise.
	always @(posedge clock_i)
	begin
		if (rst_i)
			rdata_o <= 32'h00000000;
		else if (rd_i)
		begin
			case (addr_i)
				`PSM_REG_CTRL_A, `PSM_REG_CTRL_C, `PSM_REG_CTRL_D:
					rdata_o <= {23'h000000, ctrl_reg[addr_i[1:0]]};
				`PSM_REG_PRIO_A:
					rdata_o <= {14'h0000, prio_reg[0]};
				`PSM_REG_PRIO_C:
					rdata_o <= {14'h0000, prio_reg[1]};
				`PSM_REG_PRIO_D:
					rdata_o <= {14'h0000, prio_reg[2]};
				`PSM_REG_RAMP:
					rdata_o <= {26'h0000000, ramp_rate_o};
				`PSM_REG_TOL:
					rdata_o <= {16'h0000, tol_reg};
				`PSM_REG_STATUS:
					rdata_o <= {15'h0000, crystal_loss_o, lock_loss_flag_o, holdover_o, frequency_fault_flag[3:0], signal_loss_flag};
				`PSM_REG_SELECT:
					rdata_o <= {23'h000000, sel_o};
				default:
				begin
					if (addr_i >= `PSM_REG_EXP0 && addr_i <= `PSM_REG_EXP3)
						rdata_o <= {16'h0000, exp_reg[addr_i[1:0]]};
					else
						rdata_o <= 32'h00000000;
				end
			endcase
		end
		else
			rdata_o <= 32'h00000000;
	end

endmodule // psm_top

// file: verification/psm_top_assertions.sv
module psm_chk #(
	parameter SETTLE_CYC = 4
) (
	input logic        clock_i,
	input logic        rst_i,
	input logic [5:0]  in_clk_i,
	input logic        crystal_reference_pins_i,
	input logic [2:0]  loop_freq_err_i,
	input logic        rd_i,
	input logic [31:0] rdata_o,
	input logic [8:0]  sel_o,
	input logic [2:0]  holdover_o,
	input logic [2:0]  lock_loss_flag_o,
	input logic [2:0]  phase_absorb_o,
	input logic [2:0]  fast_bw_o,
	input logic [5:0]  ramp_rate_o,
	input logic [5:0]  signal_loss_flag_o,
	input logic        crystal_loss_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	sel_c_range_a: assert property (!holdover_o[1] |-> !sel_o[5])
		else $error("loop C selected an input outside its set");
	ramp_code_max_a: assert property (ramp_rate_o <= 6'h29)
		else $error("ramp code above top setting");
	loss_clear_a: assert property ($rose(in_clk_i[4]) |-> ##[1:3] !signal_loss_flag_o[4])
		else $error("extra input loss not cleared by edge");
	xtal_clear_a: assert property ($rose(crystal_reference_pins_i) |-> ##[1:3] !crystal_loss_o)
		else $error("crystal loss not cleared by edge");
	lol_set_a: assert property (loop_freq_err_i[1] |-> ##[0:2] lock_loss_flag_o[1])
		else $error("lock loss missing on loop C error");
	lol_hold_a: assert property ($fell(lock_loss_flag_o[1]) |->
		!$past(loop_freq_err_i[1]) && !$past(loop_freq_err_i[1], SETTLE_CYC))
		else $error("lock loss cleared before settle time");
	hold_lol_a: assert property (holdover_o[1] |-> lock_loss_flag_o[1])
		else $error("holdover without lock loss");
	absorb_pulse_a: assert property (phase_absorb_o[1] |=> !phase_absorb_o[1])
		else $error("absorb pulse longer than one cycle");
	absorb_switch_a: assert property (phase_absorb_o[1] |-> sel_o[5:3] != $past(sel_o[5:3]))
		else $error("absorb pulse without an input switch");
	fast_pullin_a: assert property (fast_bw_o[1] |-> lock_loss_flag_o[1])
		else $error("fast bandwidth outside pull-in");
	rd_idle_a: assert property (!rd_i |=> rdata_o == 32'h0)
		else $error("read data without read strobe");
	cover property ($rose(holdover_o[1]));
	cover property ($fell(lock_loss_flag_o[1]));
	cover property (phase_absorb_o[1]);
endmodule // psm_chk

bind psm_top psm_chk #(.SETTLE_CYC(SETTLE_CYC)) u_chk (.clock_i(clock_i), .rst_i(rst_i),
	.in_clk_i(in_clk_i), .crystal_reference_pins_i(crystal_reference_pins_i),
	.loop_freq_err_i(loop_freq_err_i), .rd_i(rd_i), .rdata_o(rdata_o), .sel_o(sel_o),
	.holdover_o(holdover_o), .lock_loss_flag_o(lock_loss_flag_o), .phase_absorb_o(phase_absorb_o),
	.fast_bw_o(fast_bw_o), .ramp_rate_o(ramp_rate_o), .signal_loss_flag_o(signal_loss_flag_o),
	.crystal_loss_o(crystal_loss_o));

// file: verification/psm_src.sv
module psm_src (
	input  logic       clock_i,
	input  logic       rst_i,
	input  logic [6:0] stop_i,
	input  logic       gap_i,
	output logic [5:0] clk_o,
	output logic       xtal_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] cnt_reg;
	logic       ph;
	always_ff @(posedge clock_i)
		cnt_reg <= rst_i ? 3'h0 : cnt_reg + 3'h1;
	// Dropping one pulse in four removes two cycles of eight, the worst gapping still valid.
	assign ph = cnt_reg[0] & !(gap_i && cnt_reg[2:1] == 2'h3);
	assign clk_o = {{5{cnt_reg[0]}}, ph} & ~stop_i[5:0];
	assign xtal_o = cnt_reg[0] & !stop_i[6];
endmodule // psm_src

// file: verification/tb.sv
`include "psm_defs.vh"
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [5:0]  in_clk;
	logic        xtal;
	logic [2:0]  err = 3'h7;
	logic [3:0]  addr_i = 4'h0;
	logic [31:0] wdata_i = 32'h0;
	logic        wr_i = 1'b0;
	logic        rd_i = 1'b0;
	logic [6:0]  stop = 7'h00;
	logic        gap = 1'b0;
	logic [31:0] rdata_o;
	logic [8:0]  sel_o;
	logic [2:0]  hold, lock_loss_flag, absorb, ramp, fast;
	logic [5:0]  rate, loss;
	logic [3:0]  fault;
	logic        xloss;
	int          n_errors = 0;
	int          n_tests = 0;
	psm_top #(.WIN_CYC(40), .GAP_CYC(8), .SETTLE_CYC(4)) u_dut (.clock_i(clock_i), .rst_i(rst_i),
		.in_clk_i(in_clk), .crystal_reference_pins_i(xtal), .loop_freq_err_i(err), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sel_o(sel_o),
		.holdover_o(hold), .lock_loss_flag_o(lock_loss_flag), .phase_absorb_o(absorb), .ramp_active_o(ramp),
		.fast_bw_o(fast), .ramp_rate_o(rate), .signal_loss_flag_o(loss),
		.frequency_fault_flag_o(fault), .crystal_loss_o(xloss));
	psm_src u_src (.clock_i(clock_i), .rst_i(rst_i), .stop_i(stop), .gap_i(gap), .clk_o(in_clk),
		.xtal_o(xtal));
	initial
	begin
		forever #20 clock_i = ~clock_i;
	end
	task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", n, exp, got);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clock_i);
		wr_i <= 1'b0;
	endtask
	task automatic rdc(input string n, input logic [3:0] a, input logic [31:0] e);
		@(posedge clock_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clock_i);
		rd_i <= 1'b0;
		@(negedge clock_i);
		chk(n, rdata_o, e);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clock_i);
	endtask
	task automatic src(input logic [6:0] s, input logic g);
		@(posedge clock_i);
		stop <= s;
		gap <= g;
	endtask
	task t_reset;
		@(negedge clock_i);
		chk("reset_out", {sel_o, hold, lock_loss_flag, loss}, {9'h000, 3'h0, 3'h7, 6'h3F});
		rdc("ctrl_a", `PSM_REG_CTRL_A, 32'h0);
		rdc("tol", `PSM_REG_TOL, 32'h10);
		rdc("exp0", `PSM_REG_EXP0, 32'h3E8);
		rdc("unmapped", 4'hE, 32'h0);
	endtask
	task t_ramp;
		wr(`PSM_REG_RAMP, 32'h3F);
		cyc(2);
		chk("ramp_clamp", rate, 6'h29);
		wr(`PSM_REG_RAMP, 32'h28);
		cyc(2);
		chk("ramp", rate, 6'h28);
	endtask
	task t_mon;
		for (int i = 0; i < 4; i++)
			wr(`PSM_REG_EXP0 + i[3:0], 32'h14);
		cyc(90);
		chk("flags", {xloss, fault, loss}, 11'h000);
		src(7'h00, 1'b1);
		cyc(120);
		chk("gapped", {xloss, fault, loss}, 11'h000);
		src(7'h52, 1'b0);
		cyc(16);
		chk("loss", {xloss, loss}, 7'h52);
		cyc(90);
		chk("fault", fault, 4'h2);
		src(7'h00, 1'b0);
		cyc(90);
		chk("recover", {xloss, fault, loss}, 11'h000);
	endtask
	task t_manual;
		wr(`PSM_REG_CTRL_D, 32'h5);
		wr(`PSM_REG_CTRL_A, 32'h4);
		cyc(4);
		chk("sel_d", {sel_o[8:6], hold[2]}, 4'hA);
		chk("hold_a_bad", hold[0], 1'b1);
		wr(`PSM_REG_CTRL_A, 32'h2);
		cyc(4);
		chk("sel_a", {sel_o[2:0], hold[0]}, 4'h4);
		src(7'h04, 1'b0);
		cyc(16);
		chk("hold_a", hold[0], 1'b1);
		src(7'h00, 1'b0);
		cyc(16);
		chk("exit_a", hold[0], 1'b0);
		wr(`PSM_REG_PRIO_D, 32'h249);
		wr(`PSM_REG_CTRL_D, 32'hD);
		cyc(4);
		chk("auto_d", sel_o[8:6], 3'h0);
		wr(`PSM_REG_PRIO_D, 32'h9249);
		cyc(4);
		chk("auto_d_off", sel_o[8:6], 3'h5);
	endtask
	task t_auto;
		// Input zero stays disabled so that the non-revertive hold on the current input does not mask the pick.
		wr(`PSM_REG_PRIO_C, 32'h98);
		wr(`PSM_REG_CTRL_C, 32'h1A8);
		cyc(4);
		chk("sel_c", sel_o[5:3], 3'h1);
		src(7'h02, 1'b0);
		cyc(16);
		chk("sel_c_fail", sel_o[5:3], 3'h2);
		src(7'h00, 1'b0);
		cyc(90);
		chk("nonrevert", sel_o[5:3], 3'h2);
		wr(`PSM_REG_CTRL_C, 32'h1F8);
		cyc(2);
		chk("absorb_c", absorb[1], 1'b1);
		cyc(2);
		chk("revert", {sel_o[5:3], ramp[1], fast[1]}, 5'h07);
		src(7'h07, 1'b0);
		cyc(16);
		chk("hold_c", {hold[1], lock_loss_flag[1]}, 2'h3);
		src(7'h00, 1'b0);
		cyc(90);
		chk("exit_c", {hold[1], ramp[1], fast[1]}, 3'h3);
		@(posedge clock_i);
		err <= 3'h5;
		cyc(8);
		chk("lock_c", {lock_loss_flag[1], ramp[1], fast[1]}, 3'h0);
		@(posedge clock_i);
		err <= 3'h7;
		cyc(4);
		chk("unlock_c", lock_loss_flag[1], 1'b1);
	endtask
	task finish_test;
		$display("comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge clock_i);
		n_errors++;
		finish_test;
	end
	initial
	begin
		repeat (10) @(posedge clock_i);
		rst_i <= 1'b0;
		t_reset;
		t_ramp;
		t_mon;
		t_manual;
		t_auto;
		finish_test;
	end
endmodule // tb
